// ---- logic/dic_consts.vh ----
// Purpose: constants for the ddr2 init command sequencer
// Assumes: 125 MHz aclk, axi4-lite register port
// Notes: offsets are byte addresses of aligned 32-bit words
`ifndef DIC_CONSTS_VH
`define DIC_CONSTS_VH
// ==========================================================
// register offsets
`define DIC_OFF_MODE 4'h0
`define DIC_OFF_RTR 4'h4
`define DIC_OFF_CFG 4'h8
`define DIC_OFF_TIM 4'hc
`define DIC_OFF_MDR 5'h10
`define DIC_OFF_STAT 5'h14
// ==========================================================
// mode field codes
`define DIC_MODE_NORMAL 3'h0
`define DIC_MODE_NOP 3'h1
`define DIC_MODE_PALL 3'h2
`define DIC_MODE_MRS 3'h3
`define DIC_MODE_REF 3'h4
`define DIC_MODE_EMRS 3'h5
// ==========================================================
// configuration field positions
`define DIC_CFG_DLL_BIT 7
`define DIC_CFG_OCD_LSB 12
`define DIC_CFG_OCD_MSB 14
// ==========================================================
// reset values
`define DIC_RTR_RESET 12'h000
`define DIC_CFG_RESET 32'h00000000
// burst length code for 8
`define DIC_BL8_CODE 3'h3
// ==========================================================
// timing
`define DIC_CLK_MHZ 125
`define DIC_PAUSE_US 200
`define DIC_PAUSE_CYC (`DIC_PAUSE_US * `DIC_CLK_MHZ)
// sdram command encodings {ras_n,cas_n,we_n}
`define DIC_CMD_NOP 3'h7
`define DIC_CMD_PRE 3'h2
`define DIC_CMD_REF 3'h1
`define DIC_CMD_MRS 3'h0
`endif

// ---- logic/dic_cmd_issue.v ----
// Purpose: drives one sdram command for one clock cycle
// Assumes: request is a one-cycle pulse, never during busy
// Notes: idle output is nop; address and bank are held between
`timescale 1ns/1ps
`default_nettype none
`include "dic_consts.vh"
module dic_cmd_issue #(
  parameter AW = 14
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // request
  input wire req,
  input wire [2:0] req_cmd,
  input wire [2:0] req_ba,
  input wire [AW-1:0] req_addr,
  // memory command pins
  output reg [2:0] cmd,
  output reg [2:0] ba,
  output reg [AW-1:0] addr,
  output reg cs_n
);
  // register the command for exactly one cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd <= `DIC_CMD_NOP;
      ba <= 3'h0;
      addr <= {AW{1'b0}};
      cs_n <= 1'b1;
    end else if (req) begin
      cmd <= req_cmd;
      ba <= req_ba;
      addr <= req_addr;
      cs_n <= 1'b0;
    end else begin
      cmd <= `DIC_CMD_NOP;
      cs_n <= 1'b1;
    end
  end
endmodule // dic_cmd_issue
`default_nettype wire

// ---- logic/dic_sequencer.v ----
// Purpose: register slave and init command sequencer of the
//   sdram_memory_controller for ddr2 parts
// Assumes: memory write port is a simple valid/ready strobe
// Notes: normal data cycles are outside this block
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dic_consts.vh"
module dic_sequencer #(
  parameter AW = 14,
  parameter PAUSE_CYC = `DIC_PAUSE_CYC
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // memory-space write strobe
  input wire mem_wr_valid,
  input wire [2:0] mem_wr_ba,
  output reg mem_wr_ready,
  // memory pins
  output reg mem_clk_en,
  output reg mem_cke,
  output wire [2:0] mem_cmd,
  output wire [2:0] mem_ba,
  output wire [AW-1:0] mem_addr,
  output wire mem_cs_n
);
  // ========================================================
  // registers
  reg [2:0] mode_reg;
  reg [11:0] rtr_reg;
  reg [31:0] cfg_reg;
  reg [31:0] tim_reg;
  reg [2:0] mdr_reg;
  reg [7:0] aw_addr_reg;
  reg aw_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_held_reg;
  reg nop_seen_reg;
  reg [31:0] pause_reg;
  reg [11:0] ref_cnt_reg;
  reg ref_due_reg;
  reg iss_req_reg;
  reg [2:0] iss_cmd_reg;
  reg [2:0] iss_ba_reg;
  reg [AW-1:0] iss_addr_reg;
  wire pause_busy;
  wire do_write;
  wire [31:0] mrs_word;
  wire [31:0] emrs1_word;
  wire [7:0] idx_mode;
  wire [7:0] idx_rtr;
  wire [7:0] idx_cfg;
  wire [7:0] idx_tim;
  wire [7:0] idx_mdr;
  wire [7:0] idx_stat;
  assign pause_busy = (pause_reg != 32'h0);
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  // full byte offsets so that aliases above 0x3f decode as unmapped
  assign idx_mode = {4'h0, `DIC_OFF_MODE};
  assign idx_rtr = {4'h0, `DIC_OFF_RTR};
  assign idx_cfg = {4'h0, `DIC_OFF_CFG};
  assign idx_tim = {4'h0, `DIC_OFF_TIM};
  assign idx_mdr = {3'h0, `DIC_OFF_MDR};
  assign idx_stat = {3'h0, `DIC_OFF_STAT};
  // ========================================================
  // axi4-lite write channels, taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // write response; unmapped offsets answer slverr
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_reg[7:2] > idx_stat[7:2]) begin
        s_axi_bresp <= 2'h2;
      end else begin
        s_axi_bresp <= 2'h0;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // register storage, each implemented byte lane written by its own strobe
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= `DIC_MODE_NORMAL;
      rtr_reg <= `DIC_RTR_RESET;
      cfg_reg <= `DIC_CFG_RESET;
      tim_reg <= 32'h0;
      mdr_reg <= 3'h0;
    end else if (do_write) begin
      case (aw_addr_reg[7:2])
        idx_mode[7:2]: begin
          if (w_strb_reg[0]) mode_reg <= w_data_reg[2:0];
        end
        idx_rtr[7:2]: begin
          if (w_strb_reg[0]) rtr_reg[7:0] <= w_data_reg[7:0];
          if (w_strb_reg[1]) rtr_reg[11:8] <= w_data_reg[11:8];
        end
        idx_cfg[7:2]: begin
          if (w_strb_reg[0]) cfg_reg[7:0] <= w_data_reg[7:0];
          if (w_strb_reg[1]) cfg_reg[15:8] <= w_data_reg[15:8];
          if (w_strb_reg[2]) cfg_reg[23:16] <= w_data_reg[23:16];
          if (w_strb_reg[3]) cfg_reg[31:24] <= w_data_reg[31:24];
        end
        idx_tim[7:2]: begin
          if (w_strb_reg[0]) tim_reg[7:0] <= w_data_reg[7:0];
          if (w_strb_reg[1]) tim_reg[15:8] <= w_data_reg[15:8];
          if (w_strb_reg[2]) tim_reg[23:16] <= w_data_reg[23:16];
          if (w_strb_reg[3]) tim_reg[31:24] <= w_data_reg[31:24];
        end
        idx_mdr[7:2]: begin
          if (w_strb_reg[0]) mdr_reg <= w_data_reg[2:0];
        end
        default: begin
          // status and unmapped offsets hold no storage
        end
      endcase
    end
  end
  // ========================================================
  // axi4-lite read; status shows clock, cke and pause state
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr[7:2])
        idx_mode[7:2]: s_axi_rdata <= {29'h0, mode_reg};
        idx_rtr[7:2]: s_axi_rdata <= {20'h0, rtr_reg};
        idx_cfg[7:2]: s_axi_rdata <= cfg_reg;
        idx_tim[7:2]: s_axi_rdata <= tim_reg;
        idx_mdr[7:2]: s_axi_rdata <= {29'h0, mdr_reg};
        idx_stat[7:2]: begin
          s_axi_rdata <= {29'h0, pause_busy, mem_cke, mem_clk_en};
        end
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ========================================================
  // mode register words: cas latency from config, burst of eight
  // fixed burst eight
  assign mrs_word = {23'h0, cfg_reg[`DIC_CFG_DLL_BIT], 1'b0,
    cfg_reg[6:4], 1'b0, `DIC_BL8_CODE};
  assign emrs1_word = {21'h0, cfg_reg[`DIC_CFG_OCD_MSB:`DIC_CFG_OCD_LSB],
    8'h00};
  // memory write accepted at most every other cycle when no pause, no refresh due and no command pending
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_wr_ready <= 1'b0;
    end else begin
      mem_wr_ready <= !pause_busy && !ref_due_reg && !mem_wr_ready
        && !iss_req_reg;
    end
  end
  // ========================================================
  // command decode from mode field on each memory write
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_clk_en <= 1'b0;
      mem_cke <= 1'b0;
      nop_seen_reg <= 1'b0;
      pause_reg <= 32'h0;
      iss_req_reg <= 1'b0;
      iss_cmd_reg <= `DIC_CMD_NOP;
      iss_ba_reg <= 3'h0;
      iss_addr_reg <= {AW{1'b0}};
    end else begin
      iss_req_reg <= 1'b0;
      if (pause_busy) begin
        pause_reg <= pause_reg - 32'h1;
      end
      if (mem_wr_valid && mem_wr_ready) begin
        case (mode_reg)
          `DIC_MODE_NOP: begin
            if (!nop_seen_reg) begin
              nop_seen_reg <= 1'b1;
              mem_clk_en <= 1'b1;
              pause_reg <= PAUSE_CYC;
            end else begin
              mem_cke <= 1'b1;
            end
          end
          `DIC_MODE_PALL: begin
            iss_req_reg <= 1'b1;
            iss_cmd_reg <= `DIC_CMD_PRE;
            iss_addr_reg <= {{(AW-11){1'b0}}, 1'b1, 10'h000};
          end
          `DIC_MODE_MRS: begin
            iss_req_reg <= 1'b1;
            iss_cmd_reg <= `DIC_CMD_MRS;
            iss_ba_reg <= mem_wr_ba;
            iss_addr_reg <= mrs_word[AW-1:0];
          end
          `DIC_MODE_REF: begin
            iss_req_reg <= 1'b1;
            iss_cmd_reg <= `DIC_CMD_REF;
          end
          `DIC_MODE_EMRS: begin
            iss_req_reg <= 1'b1;
            iss_cmd_reg <= `DIC_CMD_MRS;
            iss_ba_reg <= mem_wr_ba;
            if (mem_wr_ba == 3'h1) begin
              iss_addr_reg <= emrs1_word[AW-1:0];
            end else begin
              iss_addr_reg <= {AW{1'b0}};
            end
          end
          default: begin
          end
        endcase
      end else if (ref_due_reg && mode_reg == `DIC_MODE_NORMAL
          && !iss_req_reg) begin
        iss_req_reg <= 1'b1;
        iss_cmd_reg <= `DIC_CMD_REF;
      end
    end
  end
  // ========================================================
  // refresh timer counting the programmed interval
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_reg <= 12'h0;
      ref_due_reg <= 1'b0;
    end else begin
      if (iss_req_reg && iss_cmd_reg == `DIC_CMD_REF) begin
        ref_due_reg <= 1'b0;
      end
      if (mode_reg != `DIC_MODE_NORMAL || rtr_reg == 12'h0
          || !mem_cke) begin
        ref_cnt_reg <= 12'h0;
      end else if (ref_cnt_reg >= rtr_reg - 12'h1) begin
        // interval elapsed; set wins over clear
        ref_cnt_reg <= 12'h0;
        ref_due_reg <= 1'b1;
      end else begin
        ref_cnt_reg <= ref_cnt_reg + 12'h1;
      end
    end
  end
  // ========================================================
  // one-cycle command driver
  dic_cmd_issue #(
    .AW(AW)
  ) u_issue (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(iss_req_reg),
    .req_cmd(iss_cmd_reg),
    .req_ba(iss_ba_reg),
    .req_addr(iss_addr_reg),
    .cmd(mem_cmd),
    .ba(mem_ba),
    .addr(mem_addr),
    .cs_n(mem_cs_n)
  );
endmodule // dic_sequencer
`default_nettype wire

// ---- tb/dic_sequencer_asserts.sv ----
// Purpose: port checks for dic_sequencer
// Assumes: pause count above eight cycles
// Notes: bound to every instance
`timescale 1ns/1ps
`default_nettype none
`include "dic_consts.vh"
module dic_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory side
  input wire logic mem_wr_valid,
  input wire logic mem_wr_ready,
  input wire logic mem_clk_en,
  input wire logic mem_cke,
  input wire logic [2:0] mem_cmd,
  input wire logic mem_cs_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // sequences
  sequence mem_take;
    mem_wr_valid && mem_wr_ready;
  endsequence
  sequence quiet8;
    (!mem_wr_ready && mem_cs_n) [*8];
  endsequence
  // ==========================================================
  // assertions
  ready_pulse_a: assert property (mem_take |=> !mem_wr_ready)
    else $error("memory ready held two cycles");
  cmd_one_a: assert property (!mem_cs_n |=> mem_cs_n)
    else $error("command longer than one cycle");
  idle_nop_a: assert property (mem_cs_n |-> mem_cmd == `DIC_CMD_NOP)
    else $error("idle command not nop");
  pause_hold_a: assert property ($rose(mem_clk_en) |-> quiet8)
    else $error("activity during clock pause");
  clk_keep_a: assert property (mem_clk_en |=> mem_clk_en)
    else $error("memory clock stopped");
  cke_order_a: assert property (mem_cke |-> mem_clk_en)
    else $error("cke high without clock");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
endmodule // dic_chk
bind dic_sequencer dic_chk dic_chk_i (.aclk, .aresetn, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .mem_wr_valid,
  .mem_wr_ready, .mem_clk_en, .mem_cke, .mem_cmd, .mem_cs_n);
`default_nettype wire

// ---- tb/dic_mem_model.sv ----
// Purpose: sdram device seen from its command pins
// Assumes: one command per cs_n low cycle
// Notes: reports each command one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "dic_consts.vh"
module dic_mem_model #(
  parameter AW = 14
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // memory pins
  input wire logic mem_clk_en,
  input wire logic mem_cke,
  input wire logic [2:0] mem_cmd,
  input wire logic [2:0] mem_ba,
  input wire logic [AW-1:0] mem_addr,
  input wire logic mem_cs_n,
  // observed state
  output logic ev,
  output logic [19:0] ev_word,
  output logic [2:0] burst_code,
  output int bad
);
  // ==========================================================
  // command intake
  always @(posedge aclk) begin
    ev <= 1'b0;
    if (!aresetn) begin
      bad <= 0;
      burst_code <= 3'h0;
    end else if (!mem_cs_n) begin
      ev <= 1'b1;
      ev_word <= {mem_cmd, mem_ba, 14'(mem_addr)};
      // commands need running clock and cke
      if (!(mem_clk_en && mem_cke))
        bad <= bad + 1;
      if (mem_cmd == `DIC_CMD_MRS && mem_ba == 3'h0)
        burst_code <= mem_addr[2:0];
    end
  end
endmodule // dic_mem_model
`default_nettype wire

// ---- tb/dic_sequencer_tb.sv ----
// Purpose: self-checking bench for dic_sequencer
// Assumes: pause shortened to 20 cycles
// Notes: expected commands queued at each taken write
`timescale 1ns/1ps
`default_nettype none
`include "dic_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module dic_sequencer_tb;
  localparam int PAUSE = 20;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic mem_wr_valid = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, cfg_m = 0, seed = 32'h30b7;
  logic [2:0] mem_wr_ba = 0, mem_cmd, mem_ba, burst_code, mode_m = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mem_wr_ready, mem_clk_en, mem_cke, mem_cs_n, ev;
  logic [13:0] mem_addr;
  logic [19:0] ev_word;
  logic [39:0] e, exp_q[$];
  int errors = 0, num_checks = 0, cyc = 0, t_take = 0, t0, n_ref = 0, bad;
  bit ref_ok = 0;
  dic_sequencer #(.AW(14), .PAUSE_CYC(PAUSE)) dic_sequencer_i (.aclk,
    .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mem_wr_valid, .mem_wr_ba, .mem_wr_ready, .mem_clk_en, .mem_cke,
    .mem_cmd, .mem_ba, .mem_addr, .mem_cs_n);
  dic_mem_model #(.AW(14)) dic_mem_model_i (.aclk, .aresetn, .mem_clk_en,
    .mem_cke, .mem_cmd, .mem_ba, .mem_addr, .mem_cs_n, .ev, .ev_word,
    .burst_code, .bad);
  // ==========================================================
  // clock, cycle count and timeout
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      errors++;
      end_sim();
    end
  end
  // compare each issued command with the model queue, or once ref_ok is set and the queue is empty, with REF
  always @(posedge aclk) if (ev) begin
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK(ev_word & e[39:20], e[19:0])
    end else if (ref_ok) begin
      n_ref++;
      `CHK(ev_word[19:17], `DIC_CMD_REF)
    end else `CHK(ev, 1'b0)
  end
  // ==========================================================
  // helpers
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic axw(input [7:0] a, input [31:0] d, input [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    `CHK(s_axi_bresp, r)
    // one idle edge so the next call never reasserts bready at once
    @(posedge aclk);
  endtask
  task automatic axr(input [7:0] a, input [31:0] d, input [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    `CHK({s_axi_rresp, s_axi_rdata}, {r, d})
    // one idle edge so the next call never reasserts rready at once
    @(posedge aclk);
  endtask
  task automatic md(input [2:0] m);
    mode_m = m;
    axw(`DIC_OFF_MODE, {29'h0, m}, 2'h0);
  endtask
  task automatic cf(input [31:0] v);
    cfg_m = v;
    axw(`DIC_OFF_CFG, v, 2'h0);
  endtask
  // one memory-space write, queueing the command it should issue
  task automatic mw(input [2:0] ba);
    mem_wr_ba <= ba;
    mem_wr_valid <= 1;
    do @(posedge aclk); while (mem_wr_ready !== 1'b1);
    mem_wr_valid <= 0;
    t_take = cyc;
    case (mode_m)
      3'h2: exp_q.push_back({20'he0400, `DIC_CMD_PRE, 17'h0400});
      3'h3: exp_q.push_back({20'hfffff, `DIC_CMD_MRS, ba, 5'h0, cfg_m[7],
        1'b0, cfg_m[6:4], 1'b0, `DIC_BL8_CODE});
      3'h4: exp_q.push_back({20'he0000, `DIC_CMD_REF, 17'h0});
      3'h5: exp_q.push_back({20'hfffff, `DIC_CMD_MRS, ba, 3'h0,
        (ba == 3'h1) ? cfg_m[14:12] : 3'h0, 8'h0});
      default: ;
    endcase
    repeat (4) @(posedge aclk);
  endtask
  task end_sim;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int i = 0; i < 12; i += 4) axr(8'(i), 32'h0, 2'h0);
    axr(8'h18, 32'h0, 2'h2);
    axw(8'h18, xs(), 2'h2);
    axw(`DIC_OFF_MDR, 32'h6, 2'h0);
    axr(`DIC_OFF_MDR, 32'h6, 2'h0);
    t0 = xs();
    axw(`DIC_OFF_TIM, t0, 2'h0);
    axr(`DIC_OFF_TIM, t0, 2'h0);
    cf(xs() & 32'h70);
    md(`DIC_MODE_NOP);
    mw(3'(xs()));
    `CHK({mem_clk_en, mem_cke}, 2'b10)
    t0 = t_take;
    mw(3'(xs()));
    `CHK(t_take - t0 >= PAUSE, 1'b1)
    `CHK(mem_cke, 1'b1)
    md(`DIC_MODE_PALL);
    mw(3'(xs()));
    md(`DIC_MODE_EMRS);
    mw(3'h2);
    mw(3'h3);
    mw(3'h1);
    repeat (200) @(posedge aclk);
    cf(cfg_m | 32'h80);
    md(`DIC_MODE_MRS);
    mw(3'h0);
    md(`DIC_MODE_PALL);
    mw(3'(xs()));
    md(`DIC_MODE_REF);
    mw(3'(xs()));
    mw(3'(xs()));
    cf(cfg_m & ~32'h80);
    md(`DIC_MODE_MRS);
    mw(3'h0);
    cf(cfg_m | 32'h7000);
    md(`DIC_MODE_EMRS);
    mw(3'h1);
    cf(cfg_m & ~32'h7000);
    mw(3'h1);
    md(`DIC_MODE_NORMAL);
    mw(3'(xs()));
    mw(3'(xs()));
    axr(`DIC_OFF_STAT, 32'h3, 2'h0);
    ref_ok = 1;
    axw(`DIC_OFF_RTR, 32'h20, 2'h0);
    axr(`DIC_OFF_RTR, 32'h20, 2'h0);
    repeat (320) @(posedge aclk);
    `CHK(n_ref >= 9 && n_ref <= 10, 1'b1)
    `CHK(exp_q.size(), 0)
    `CHK(bad, 0)
    `CHK(burst_code, `DIC_BL8_CODE)
    end_sim();
  end
endmodule // dic_sequencer_tb
`default_nettype wire
